// >>> rtl/rsp_pkg.sv
// package: register map, policy codes and timing constants for the reset and stop policy block
package rsp_pkg;
  // register byte offsets
  localparam logic [3:0] RSP_OFS_POLICY = 4'h0;
  localparam logic [3:0] RSP_OFS_CTRL = 4'h4;
  localparam logic [3:0] RSP_OFS_STATUS = 4'h8;
  // value after reset of the policy setting
  localparam logic [7:0] RSP_POLICY_RESET = 8'h0e;
  // control register bit positions
  localparam int RSP_CTRL_UGRS_LO = 0;
  localparam int RSP_CTRL_WPS_LO = 8;
  localparam int RSP_CTRL_CLR_BIT = 16;
  // status register bit positions
  localparam int RSP_ST_SHUTOFF = 0;
  localparam int RSP_ST_ALARM = 1;
  localparam int RSP_ST_PSTOP = 2;
  localparam int RSP_ST_DECEL = 3;
  localparam int RSP_ST_RSTACC = 4;
  localparam int RSP_ST_CONN = 5;
  localparam int RSP_ST_REJ = 6;
  // clock and disconnect timing
  localparam int RSP_CLK_HZ = 100_000_000;
  localparam int RSP_DISC_MS = 1000;
  localparam int RSP_DISC_CYCLES = (RSP_CLK_HZ / 1000) * RSP_DISC_MS;
  // operation modes
  typedef enum logic [1:0] {RSP_MODE_PANEL, RSP_MODE_EXT, RSP_MODE_NET} rsp_mode_t;
  // axi response codes
  localparam logic [1:0] RSP_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSP_RESP_SLVERR = 2'h2;
endpackage : rsp_pkg

// >>> rtl/rsp_sync.sv
// two flip-flop synchroniser for a single asynchronous level
`timescale 1ns/100ps
`default_nettype none
module rsp_sync (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // asynchronous level in, synchronous level out
  input wire logic d,
  output logic q
);
  import rsp_pkg::*;
  logic meta_reg; // first stage, read only by q
  // two stage shift
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : rsp_sync
`default_nettype wire

// >>> rtl/rsp_top.sv
// reset acceptance, operator unit loss and panel stop policy with axi4-lite registers
//
// What this block does
// - policy resets to 14; only 0-3, 14-17
// - odd policy codes: reset only while tripped
// - policies 2,3,16,17: unit loss shuts output
// - policies 0-3: stop key only panel mode
// - policies 14-17: stop key in every mode
// - policy writable while running despite protect
// - parameter clear leaves policy untouched
// - policy writable only when group select zero
// - unit lost over 1s raises alarm stop under policies 2,3,16,17
// - accepted reset clears accumulators, shuts output only while running
// - unit absent since power-on is no alarm
// - stop key halt holds panel stop state for policies 14-17
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module rsp_top #(
  parameter int DISC_CYCLES = rsp_pkg::RSP_DISC_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // operator unit and reset pins (asynchronous)
  input wire logic unit_connected,
  input wire logic unit_stop_key,
  input wire logic panel_stop_reset,
  input wire logic external_reset_input,
  // drive state from the same clock domain
  input wire logic comm_reset_req,
  input wire logic trip_active,
  input wire logic motor_running,
  input wire rsp_pkg::rsp_mode_t op_mode,
  // policy outputs
  output logic output_shutoff,
  output logic unit_disconnect_alarm,
  output logic panel_stop_state,
  output logic decel_stop,
  output logic reset_accepted,
  output logic clear_accumulators
);
  import rsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers
  // legal policy codes
  function automatic logic pol_legal(input logic [7:0] v);
    return (v <= 8'h03) || (v >= 8'h0e && v <= 8'h11);
  endfunction : pol_legal
  // policy restricts reset to trip
  function automatic logic pol_trip_only(input logic [7:0] v);
    return v[0];
  endfunction : pol_trip_only
  // policy shuts output on unit loss (2,3 have bit1; 16,17 have bit4)
  function automatic logic pol_loss_off(input logic [7:0] v);
    return (v <= 8'h03) ? v[1] : v[4];
  endfunction : pol_loss_off

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic conn_s, key_s, psr_s, ext_s; // synchronised pins
  rsp_sync u_conn (.aclk(aclk), .aresetn(aresetn), .d(unit_connected), .q(conn_s));
  rsp_sync u_key (.aclk(aclk), .aresetn(aresetn), .d(unit_stop_key), .q(key_s));
  rsp_sync u_psr (.aclk(aclk), .aresetn(aresetn), .d(panel_stop_reset), .q(psr_s));
  rsp_sync u_ext (.aclk(aclk), .aresetn(aresetn), .d(external_reset_input), .q(ext_s));

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] policy_reg; // stored policy setting
  logic [7:0] group_sel_reg; // user group read select
  logic [7:0] wprot_reg; // write protect select, not applied to policy
  logic reject_reg; // last policy write rejected (sticky until good write)
  logic key_d_reg, ext_d_reg; // edge detect history
  logic seen_conn_reg; // unit seen since power-on
  logic [31:0] disc_cnt_reg; // disconnect duration counter

  // write channel state
  logic aw_hold_reg, w_hold_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  // accept address and data independently, one write outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_hold_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  // write response: slverr for any offset other than policy and control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RSP_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_reg == RSP_OFS_POLICY || aw_addr_reg == RSP_OFS_CTRL) ?
                     RSP_RESP_OKAY : RSP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // policy register: legal codes only, group select zero, ignores protect and clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      policy_reg <= RSP_POLICY_RESET;
      reject_reg <= 1'b0;
    end else if (do_write && aw_addr_reg == RSP_OFS_POLICY && w_strb_reg[0]) begin
      if (pol_legal(w_data_reg[7:0]) && group_sel_reg == 8'h00) begin
        policy_reg <= w_data_reg[7:0];
        reject_reg <= 1'b0;
      end else begin
        reject_reg <= 1'b1;
      end
    end
  end

  // control register: group select and protect select; clear bit is not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      group_sel_reg <= 8'h00;
      wprot_reg <= 8'h00;
    end else if (do_write && aw_addr_reg == RSP_OFS_CTRL) begin
      if (w_strb_reg[0]) begin
        group_sel_reg <= w_data_reg[RSP_CTRL_UGRS_LO +: 8];
      end
      if (w_strb_reg[1]) begin
        wprot_reg <= w_data_reg[RSP_CTRL_WPS_LO +: 8];
      end
      // a parameter clear command has no effect on the policy setting
    end
  end

  // read channel
  logic [31:0] status_word;
  assign status_word = {25'h000_0000, reject_reg, conn_s, reset_accepted, decel_stop,
                        panel_stop_state, unit_disconnect_alarm, output_shutoff};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RSP_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RSP_RESP_OKAY;
        unique case (s_axi_araddr)
          RSP_OFS_POLICY: s_axi_rdata <= {24'h00_0000, policy_reg};
          RSP_OFS_CTRL: s_axi_rdata <= {16'h0000, wprot_reg, group_sel_reg};
          RSP_OFS_STATUS: s_axi_rdata <= status_word;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RSP_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset acceptance
  logic reset_req, reset_ok;
  assign reset_req = (ext_s && !ext_d_reg) || comm_reset_req;
  assign reset_ok = reset_req && (!pol_trip_only(policy_reg) || trip_active);

  // edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_d_reg <= 1'b0;
      ext_d_reg <= 1'b0;
    end else begin
      key_d_reg <= key_s;
      ext_d_reg <= ext_s;
    end
  end

  // accepted reset and accumulator clear pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_accepted <= 1'b0;
      clear_accumulators <= 1'b0;
    end else begin
      reset_accepted <= reset_ok;
      clear_accumulators <= reset_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operator unit loss detection
  logic disc_timeout;
  assign disc_timeout = (disc_cnt_reg >= 32'(DISC_CYCLES));

  // remember whether the unit was ever present after power-on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_conn_reg <= 1'b0;
    end else if (conn_s) begin
      seen_conn_reg <= 1'b1;
    end
  end

  // count cycles of absence after it has been seen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disc_cnt_reg <= 32'h0000_0000;
    end else if (conn_s || !seen_conn_reg || !pol_loss_off(policy_reg)) begin
      disc_cnt_reg <= 32'h0000_0000;
    end else if (!disc_timeout) begin
      disc_cnt_reg <= disc_cnt_reg + 32'h0000_0001;
    end
  end

  // alarm latches until an accepted reset with the unit back; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_disconnect_alarm <= 1'b0;
    end else if (disc_timeout && !conn_s) begin
      unit_disconnect_alarm <= 1'b1;
    end else if (reset_ok && conn_s) begin
      unit_disconnect_alarm <= 1'b0;
    end
  end

  // output shutoff: alarm stop, or reset accepted while running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_shutoff <= 1'b0;
    end else if (disc_timeout && !conn_s) begin
      output_shutoff <= 1'b1;
    end else if (reset_ok && motor_running) begin
      output_shutoff <= 1'b1;
    end else if (!motor_running && !unit_disconnect_alarm) begin
      output_shutoff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // panel stop key
  logic key_press, stop_valid;
  assign key_press = key_s && !key_d_reg && conn_s;
  assign stop_valid = key_press && ((policy_reg >= 8'h0e) ||
                      (op_mode == RSP_MODE_PANEL));

  // deceleration request held until the motor stops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      decel_stop <= 1'b0;
    end else if (stop_valid) begin
      decel_stop <= 1'b1;
    end else if (!motor_running) begin
      decel_stop <= 1'b0;
    end
  end

  // panel stop state held until panel stop reset or accepted reset; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      panel_stop_state <= 1'b0;
    end else if (stop_valid && policy_reg >= 8'h0e) begin
      panel_stop_state <= 1'b1;
    end else if (psr_s || reset_ok) begin
      panel_stop_state <= 1'b0;
    end
  end
endmodule : rsp_top
`default_nettype wire

// >>> verification/rsp_top_properties.sv
// checker: port-level properties of the policy block
`timescale 1ns/100ps
`default_nettype none
module rsp_top_checker #(
  parameter int DISC_CYCLES = 50
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // pins and drive state
  input wire logic unit_connected,
  input wire logic unit_stop_key,
  input wire logic comm_reset_req,
  input wire logic trip_active,
  input wire logic motor_running,
  // outputs
  input wire logic output_shutoff,
  input wire logic unit_disconnect_alarm,
  input wire logic decel_stop,
  input wire logic reset_accepted,
  input wire logic clear_accumulators
);
  int lo_cnt; // cycles of absence, saturating
  logic seen; // unit present since reset
  // absence count and presence flag
  always_ff @(posedge aclk) begin
    if (!aresetn || unit_connected) lo_cnt <= 0;
    else if (lo_cnt < DISC_CYCLES + 8) lo_cnt <= lo_cnt + 1;
    seen <= aresetn && (seen || unit_connected);
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_pair; reset_accepted |-> clear_accumulators; endproperty
  a_pair: assert property (p_pair) else $error("clear pulse missing");
  property p_trip; comm_reset_req && trip_active |=> reset_accepted; endproperty
  a_trip: assert property (p_trip) else $error("reset refused while tripped");
  property p_cut; reset_accepted && $past(motor_running) |-> output_shutoff; endproperty
  a_cut: assert property (p_cut) else $error("output not cut by reset");
  property p_alsh; $rose(unit_disconnect_alarm) |-> ##[0:1] output_shutoff; endproperty
  a_alsh: assert property (p_alsh) else $error("alarm without shutoff");
  property p_altm; $rose(unit_disconnect_alarm) |-> lo_cnt >= DISC_CYCLES; endproperty
  a_altm: assert property (p_altm) else $error("alarm too early");
  property p_nosn; !seen |-> !unit_disconnect_alarm; endproperty
  a_nosn: assert property (p_nosn) else $error("alarm for unit never seen");
  property p_key; $rose(decel_stop) |-> $past(unit_stop_key, 2); endproperty
  a_key: assert property (p_key) else $error("stop without key");
  property p_fall; $fell(output_shutoff) |-> !$past(motor_running) && !unit_disconnect_alarm;
  endproperty
  a_fall: assert property (p_fall) else $error("shutoff dropped early");
  property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bh: assert property (p_bh) else $error("bvalid dropped");
endmodule : rsp_top_checker
bind rsp_top rsp_top_checker #(.DISC_CYCLES(DISC_CYCLES)) rsp_top_checker_i (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_bready, .unit_connected, .unit_stop_key, .comm_reset_req, .trip_active,
  .motor_running, .output_shutoff, .unit_disconnect_alarm, .decel_stop, .reset_accepted,
  .clear_accumulators);
`default_nettype wire

// >>> verification/rsp_unit_model.sv
// operator unit model: presence, stop key, panel stop clear, reset pin
`timescale 1ns/100ps
`default_nettype none
module rsp_unit_model (
  // clock
  input wire logic aclk,
  // bench commands
  input wire logic attach,
  input wire logic press,
  input wire logic ps_clr,
  input wire logic rst_req,
  // pins toward the drive
  output logic unit_connected,
  output logic unit_stop_key,
  output logic panel_stop_reset,
  output logic external_reset_input
);
  // pins change just after the edge
  always_ff @(posedge aclk) begin
    unit_connected <= attach;
    unit_stop_key <= attach && press; // a detached unit has no key
    panel_stop_reset <= attach && ps_clr;
    external_reset_input <= rst_req;
  end
endmodule : rsp_unit_model
`default_nettype wire

// >>> verification/rsp_top_tb.sv
// testbench: registers, reset acceptance, unit loss and stop key
`timescale 1ns/100ps
`default_nettype none
module rsp_top_tb;
  import rsp_pkg::*;
  localparam int DISC = 50; // shortened loss time
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic unit_connected, unit_stop_key, panel_stop_reset, external_reset_input;
  logic comm_reset_req, trip_active, motor_running, output_shutoff, unit_disconnect_alarm;
  logic panel_stop_state, decel_stop, reset_accepted, clear_accumulators;
  logic attach, press, ps_clr, rst_req; // unit model commands
  rsp_mode_t op_mode;
  int fails = 0, n_checks = 0, n_acc = 0, n_clr = 0, a0, c0;
  rsp_top #(.DISC_CYCLES(DISC)) rsp_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .unit_connected, .unit_stop_key,
    .panel_stop_reset, .external_reset_input, .comm_reset_req, .trip_active, .motor_running,
    .op_mode, .output_shutoff, .unit_disconnect_alarm, .panel_stop_state, .decel_stop,
    .reset_accepted, .clear_accumulators);
  rsp_unit_model rsp_unit_model_i (.aclk, .attach, .press, .ps_clr, .rst_req, .unit_connected,
    .unit_stop_key, .panel_stop_reset, .external_reset_input);
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  // count one-cycle pulses
  always @(posedge aclk) begin
    n_acc <= n_acc + int'(reset_accepted === 1'b1);
    n_clr <= n_clr + int'(clear_accumulators === 1'b1);
  end
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task hang;
    check("handshake", 0, 1);
    print_verdict;
  endtask : hang
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task axi_wr(input logic [3:0] a, input logic [31:0] v);
    logic aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int k = 0; k < 100 && !b; k++) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
      if (s_axi_bvalid) begin
        b = 1;
        r = s_axi_bresp;
        s_axi_bready <= 0;
      end
    end
    if (!b) hang;
    // let an edge pass so a following call never reassigns bready in this step
    tick(1);
  endtask : axi_wr
  task axi_rd(input logic [3:0] a);
    logic ar, rv;
    ar = 0;
    rv = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int k = 0; k < 100 && !rv; k++) begin
      @(posedge aclk);
      if (!ar && s_axi_arready) begin
        ar = 1;
        s_axi_arvalid <= 0;
      end
      if (s_axi_rvalid) begin
        rv = 1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
      end
    end
    if (!rv) hang;
    // let an edge pass so a following call never reassigns rready in this step
    tick(1);
  endtask : axi_rd
  task exp_pol(input logic [31:0] e);
    axi_rd(RSP_OFS_POLICY);
    check("policy", d, e);
  endtask : exp_pol
  task pulse_comm;
    a0 = n_acc;
    c0 = n_clr;
    comm_reset_req <= 1;
    tick(1);
    comm_reset_req <= 0;
    tick(4);
  endtask : pulse_comm
  task t_regs;
    exp_pol(32'h0000_000e);
    axi_wr(RSP_OFS_POLICY, 32'h0000_0004);
    exp_pol(32'h0000_000e);
    axi_rd(RSP_OFS_STATUS);
    check("reject", 32'(d[RSP_ST_REJ]), 1);
    axi_wr(RSP_OFS_POLICY, 32'h0000_0011);
    exp_pol(32'h0000_0011);
    axi_wr(RSP_OFS_CTRL, 32'h0000_0001);
    axi_wr(RSP_OFS_POLICY, 32'h0000_0003);
    exp_pol(32'h0000_0011);
    axi_wr(RSP_OFS_CTRL, 32'h0000_0000);
    motor_running <= 1;
    axi_wr(RSP_OFS_POLICY, 32'h0000_000f);
    check("wr okay", 32'(r), 32'(RSP_RESP_OKAY));
    exp_pol(32'h0000_000f);
    motor_running <= 0;
    axi_rd(4'hc);
    check("unmapped", 32'(r), 32'(RSP_RESP_SLVERR));
    axi_wr(4'hc, 32'h0000_0001);
    check("wr unmapped", 32'(r), 32'(RSP_RESP_SLVERR));
    exp_pol(32'h0000_000f);
    $display("test regs done");
  endtask : t_regs
  task t_absent;
    axi_wr(RSP_OFS_POLICY, 32'h0000_0002);
    tick(2 * DISC);
    check("alarm", 32'(unit_disconnect_alarm), 0);
    $display("test absent done");
  endtask : t_absent
  task t_resets;
    axi_wr(RSP_OFS_POLICY, 32'h0000_0001);
    motor_running <= 1;
    pulse_comm;
    check("acc", 32'(n_acc - a0), 0);
    trip_active <= 1;
    pulse_comm;
    check("acc", 32'(n_acc - a0), 1);
    check("clr", 32'(n_clr - c0), 1);
    check("shutoff", 32'(output_shutoff), 1);
    trip_active <= 0;
    motor_running <= 0;
    axi_wr(RSP_OFS_POLICY, 32'h0000_0000);
    a0 = n_acc;
    rst_req <= 1;
    tick(8);
    rst_req <= 0;
    tick(4);
    check("acc", 32'(n_acc - a0), 1);
    $display("test resets done");
  endtask : t_resets
  task t_stop;
    logic hi;
    attach <= 1;
    tick(6);
    for (int i = 0; i < 6; i++) begin
      hi = (i >= 3);
      axi_wr(RSP_OFS_POLICY, hi ? 32'h0000_000e : 32'h0000_0000);
      op_mode <= rsp_mode_t'(i % 3);
      motor_running <= 1;
      press <= 1;
      tick(10);
      check("decel", 32'(decel_stop), 32'(hi || i == 0));
      check("pstop", 32'(panel_stop_state), 32'(hi));
      press <= 0;
      ps_clr <= 1;
      tick(8);
      ps_clr <= 0;
      check("pstop", 32'(panel_stop_state), 0);
      motor_running <= 0;
      tick(6);
    end
    $display("test stop done");
  endtask : t_stop
  task t_loss;
    axi_wr(RSP_OFS_POLICY, 32'h0000_0002);
    attach <= 0;
    tick(DISC / 2);
    check("alarm", 32'(unit_disconnect_alarm), 0);
    tick(DISC);
    check("alarm", 32'(unit_disconnect_alarm), 1);
    check("shutoff", 32'(output_shutoff), 1);
    attach <= 1;
    tick(6);
    pulse_comm;
    check("alarm", 32'(unit_disconnect_alarm), 0);
    axi_wr(RSP_OFS_POLICY, 32'h0000_0000);
    attach <= 0;
    tick(2 * DISC);
    check("alarm", 32'(unit_disconnect_alarm), 0);
    check("shutoff", 32'(output_shutoff), 0);
    $display("test loss done");
  endtask : t_loss
  // reset, then the scenarios in turn
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    s_axi_wstrb = 4'hf;
    {attach, press, ps_clr, rst_req, comm_reset_req, trip_active, motor_running} = 0;
    op_mode = RSP_MODE_PANEL;
    tick(4);
    aresetn <= 1;
    tick(1);
    t_regs;
    t_absent;
    t_resets;
    t_stop;
    t_loss;
    print_verdict;
  end
endmodule : rsp_top_tb
`default_nettype wire
